// ==== verilog/vprio_defs.vh ====
// Constants for the virtual priority filter and running level block.
`ifndef VPRIO_DEFS_VH
`define VPRIO_DEFS_VH
// System register encoding fields.
`define ENC_OP0_SYS        2'h3
`define ENC_OP1_EL1        3'h0
`define FILT_CRN           4'h4
`define FILT_CRM           4'h6
`define FILT_OP2           3'h0
`define RUN_CRN            4'hc
`define RUN_CRM            4'hb
`define RUN_OP2            3'h3
// Field layout and reset values.
`define PRIO_MSB           7
`define PRIO_W             8
`define FILT_RESET         8'h00
`define IDLE_PRIO          8'hff
`define RSVD_ZERO          24'h000000
`endif

// ==== verilog/virtual_priority_mask_running.v ====
// Virtual priority filter and running level registers with routing and traps.
`timescale 1ns/1ps
`include "vprio_defs.vh"

module virtual_priority_mask_running #(
   parameter PRIO_BITS = 8
) (
   input  wire        i_mclk,
   input  wire        i_sys_rst,
   // System register access port from the core.
   input  wire        i_acc_valid,
   input  wire        i_acc_write,
   input  wire [1:0]  i_acc_op0,
   input  wire [2:0]  i_acc_op1,
   input  wire [3:0]  i_acc_crn,
   input  wire [3:0]  i_acc_crm,
   input  wire [2:0]  i_acc_op2,
   input  wire [31:0] i_acc_wdata,
   input  wire        i_acc_ns_el1,
   // Control bits from the surrounding configuration registers.
   input  wire        i_fast_irq_route_override,
   input  wire        i_normal_irq_route_override,
   input  wire        i_sysreg_access_enable,
   input  wire        i_common_trap_control,
   // Priority state of the virtual interface.
   input  wire        i_pend_valid,
   input  wire [7:0]  i_pend_prio,
   input  wire        i_active_valid,
   input  wire [7:0]  i_active_prio,
   // Answers.
   output reg  [31:0] o_acc_rdata,
   output reg         o_acc_done,
   output reg         o_trap_el1,
   output reg         o_trap_el2,
   output reg         o_phys_filter_sel,
   output reg         o_phys_running_sel,
   output wire        o_virq_signal
);

   // ------------------------------------------------------------
   // Priority masking helpers
   // ------------------------------------------------------------
   localparam [7:0] IMPL_MASK = 8'hff << (8 - PRIO_BITS);

   function [7:0] impl_bits;
      input [7:0] v;
      begin
         impl_bits = v & IMPL_MASK;
      end
   endfunction

   reg  [7:0] filter;
   wire       hit_filter;
   wire       hit_running;
   wire       routed_virtual;
   wire       filt_legal;
   wire       run_legal;
   reg  [7:0] next_filter;
   wire [7:0] group_prio;
   wire [7:0] running_level;

   // ------------------------------------------------------------
   // Decode and routing
   // ------------------------------------------------------------
   assign hit_filter  = i_acc_op0 == `ENC_OP0_SYS && i_acc_op1 == `ENC_OP1_EL1 &&
                        i_acc_crn == `FILT_CRN && i_acc_crm == `FILT_CRM &&
                        i_acc_op2 == `FILT_OP2;
   assign hit_running = i_acc_op0 == `ENC_OP0_SYS && i_acc_op1 == `ENC_OP1_EL1 &&
                        i_acc_crn == `RUN_CRN && i_acc_crm == `RUN_CRM &&
                        i_acc_op2 == `RUN_OP2;
   assign routed_virtual = i_fast_irq_route_override | i_normal_irq_route_override;
   assign filt_legal = i_acc_valid && i_acc_ns_el1 && hit_filter && routed_virtual;
   // The running level is read-only; a write to its encoding is not claimed here.
   assign run_legal  = i_acc_valid && i_acc_ns_el1 && hit_running && routed_virtual &&
                       !i_acc_write;

   // ------------------------------------------------------------
   // Running level
   // ------------------------------------------------------------
   // Clearing bit 0 while a priority is active hides how many priority bits exist; idle reads 8'hff.
   assign group_prio    = impl_bits(i_active_prio) & 8'hfe;
   assign running_level = i_active_valid ? group_prio : `IDLE_PRIO;

   // Signalling uses the stored filter, so a write reaches it only at the clock edge that accepts the write.
   assign o_virq_signal = i_pend_valid && (impl_bits(i_pend_prio) < filter);

   // ------------------------------------------------------------
   // Filter register
   // ------------------------------------------------------------
   always @* begin
      next_filter = filter;
      if (filt_legal && i_acc_write && i_sysreg_access_enable && !i_common_trap_control) begin
         next_filter = impl_bits(i_acc_wdata[`PRIO_MSB:0]);
      end
   end

   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         filter <= `FILT_RESET;
      end else begin
         filter <= next_filter;
      end
   end

   // ------------------------------------------------------------
   // Access answer
   // ------------------------------------------------------------
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_acc_rdata        <= 32'h00000000;
         o_acc_done         <= 1'b0;
         o_trap_el1         <= 1'b0;
         o_trap_el2         <= 1'b0;
         o_phys_filter_sel  <= 1'b0;
         o_phys_running_sel <= 1'b0;
      end else begin
         o_acc_rdata        <= 32'h00000000;
         o_acc_done         <= 1'b0;
         o_trap_el1         <= 1'b0;
         o_trap_el2         <= 1'b0;
         o_phys_filter_sel  <= i_acc_valid && i_acc_ns_el1 && hit_filter &&
                               !routed_virtual;
         o_phys_running_sel <= i_acc_valid && i_acc_ns_el1 && hit_running &&
                               !routed_virtual;
         if (filt_legal || run_legal) begin
            if (!i_sysreg_access_enable) begin
               o_trap_el1 <= 1'b1;
            end else if (i_common_trap_control) begin
               o_trap_el2 <= 1'b1;
            end else begin
               o_acc_done <= 1'b1;
               if (filt_legal && !i_acc_write) begin
                  o_acc_rdata <= {`RSVD_ZERO, filter};
               end else if (run_legal) begin
                  o_acc_rdata <= {`RSVD_ZERO, running_level};
               end
            end
         end
      end
   end

endmodule // virtual_priority_mask_running

// ==== testbench/vprio_chk.sv ====
// Assertion checker for the virtual priority filter and running level block.
`timescale 1ns/1ps
module vprio_chk(input wire i_mclk, i_sys_rst, i_acc_valid, i_sysreg_access_enable,
   i_common_trap_control, i_pend_valid, o_acc_done, o_trap_el1, o_trap_el2,
   o_phys_filter_sel, o_virq_signal, input wire [31:0] o_acc_rdata);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   sequence s_el1_req; i_acc_valid && !i_sysreg_access_enable; endsequence
   a_el1_cause: assert property (o_trap_el1 |-> $past(i_acc_valid && !i_sysreg_access_enable))
      else $error("el1 trap without cause");
   a_el1_first: assert property (s_el1_req |=> !o_trap_el2) else $error("el2 over el1");
   a_el2_cause: assert property (o_trap_el2 |-> $past(i_common_trap_control))
      else $error("el2 trap without cause");
   a_done_clean: assert property (o_acc_done |-> !o_trap_el1 && !o_trap_el2)
      else $error("done with trap");
   a_route_alone: assert property (o_phys_filter_sel |-> !o_acc_done)
      else $error("routed access done");
   a_done_cause: assert property (o_acc_done |-> $past(i_acc_valid))
      else $error("done without request");
   a_rsvd_zero: assert property (o_acc_rdata[31:8] == 24'h000000)
      else $error("reserved bits set");
   a_virq_pend: assert property (o_virq_signal |-> i_pend_valid)
      else $error("signal without pending");
endmodule // vprio_chk
bind virtual_priority_mask_running vprio_chk chk_u(.*);

// ==== testbench/core_model.sv ====
// Core model issuing system register accesses.
`timescale 1ns/1ps
module core_model(input wire i_clk, output reg o_v = 0, output reg o_w = 0,
   output reg o_ns = 1, output reg [15:0] o_e = 0, output reg [31:0] o_d = 0);
   task acc(input w, input ns, input [15:0] e, input [31:0] d); begin
      @(negedge i_clk); o_v <= 1; o_w <= w; o_ns <= ns; o_e <= e; o_d <= d;
      // Released encoding and data lines show the inverse so a stale value never passes.
      @(negedge i_clk); o_v <= 0; o_e <= ~e; o_d <= ~d;
   end endtask
endmodule // core_model

// ==== testbench/virtual_priority_mask_running_test.sv ====
// Self-checking bench for the virtual priority filter and running level block.
`timescale 1ns/1ps
module virtual_priority_mask_running_test;
   localparam F = 16'hc230, R = 16'hc65b;
   reg i_mclk = 0, i_sys_rst = 1, i_fast_irq_route_override = 1;
   reg i_normal_irq_route_override = 1, i_sysreg_access_enable = 1;
   reg i_common_trap_control = 0, i_pend_valid = 0, i_active_valid = 0;
   reg [7:0] i_pend_prio = 0, i_active_prio = 0;
   integer fail_count = 0, tests_run = 0;
   wire i_acc_valid, i_acc_write, i_acc_ns_el1, o_acc_done, o_trap_el1, o_trap_el2;
   wire o_phys_filter_sel, o_phys_running_sel, o_virq_signal;
   wire [15:0] e; wire [31:0] i_acc_wdata, o_acc_rdata;
   wire [1:0] i_acc_op0; wire [2:0] i_acc_op1, i_acc_op2; wire [3:0] i_acc_crn, i_acc_crm;
   assign {i_acc_op0, i_acc_op1, i_acc_crn, i_acc_crm, i_acc_op2} = e;
   wire [4:0] st = {o_acc_done, o_trap_el1, o_trap_el2, o_phys_filter_sel, o_phys_running_sel};
   virtual_priority_mask_running #(.PRIO_BITS(5)) dut_u(.*);
   core_model core_u(.i_clk(i_mclk), .o_v(i_acc_valid), .o_w(i_acc_write),
      .o_ns(i_acc_ns_el1), .o_e(e), .o_d(i_acc_wdata));
   task chk(input [31:0] g, input [31:0] x); begin
      tests_run = tests_run + 1;
      if (g !== x) begin
         $display("CHECK FAILED %0t got %h exp %h", $time, g, x); fail_count = fail_count + 1;
      end
   end endtask
   task t_filter; begin
      core_u.acc(0, 1, F, 0); chk(rd_w(), 0);
      core_u.acc(1, 1, F, 32'hffffffff); core_u.acc(0, 1, F, 0); chk(rd_w(), 32'hf8);
      chk(st, 5'h10);
   end endtask
   function [31:0] rd_w; rd_w = o_acc_rdata; endfunction
   task t_virq; begin
      i_pend_valid = 1; i_pend_prio = 8'hf0; #1 chk(o_virq_signal, 1);
      i_pend_prio = 8'hf8; #1 chk(o_virq_signal, 0);
      core_u.acc(1, 1, F, 32'h10); i_pend_prio = 8'h17; #1 chk(o_virq_signal, 0);
      i_pend_prio = 8'h08; #1 chk(o_virq_signal, 1); i_pend_valid = 0;
   end endtask
   task t_run; begin
      core_u.acc(0, 1, R, 0); chk(rd_w(), 32'hff);
      i_active_valid = 1; i_active_prio = 8'h37;
      core_u.acc(0, 1, R, 0); chk(rd_w(), 32'h30); i_active_valid = 0;
      core_u.acc(1, 1, R, 5); chk(st, 0);
   end endtask
   task t_trap; begin
      i_sysreg_access_enable = 0; core_u.acc(1, 1, F, 32'h40); chk(st, 5'h08);
      i_common_trap_control = 1; core_u.acc(0, 1, R, 0); chk(st, 5'h08);
      i_sysreg_access_enable = 1; core_u.acc(1, 1, F, 32'h40); chk(st, 5'h04);
      i_common_trap_control = 0; core_u.acc(0, 1, F, 0); chk(rd_w(), 32'h10);
   end endtask
   task t_route; begin
      i_fast_irq_route_override = 0; i_normal_irq_route_override = 0;
      core_u.acc(0, 1, F, 0); chk(st, 5'h02);
      core_u.acc(0, 1, R, 0); chk(st, 5'h01); i_normal_irq_route_override = 1;
      core_u.acc(0, 1, F, 0); chk(st, 5'h10); core_u.acc(0, 0, F, 0); chk(st, 0);
   end endtask
   task tally_and_finish; begin
      $display("checks %0d failures %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   end endtask
   initial begin forever #2.5 i_mclk = ~i_mclk; end
   initial begin #5000; fail_count = fail_count + 1; tally_and_finish; end
   initial begin
      repeat (8) @(posedge i_mclk);
      @(negedge i_mclk) i_sys_rst = 0;
      t_filter; t_virq; t_run; t_trap; t_route; tally_and_finish;
   end
endmodule // virtual_priority_mask_running_test
